// [hsc_defines.svh]
// constants for the high-side switch timer control block
// assumes a 50 MHz core clock and the 7-bit register addresses below
`ifndef HSC_DEFINES_SVH
`define HSC_DEFINES_SVH

// register addresses and widths
`define HSC_ADDR_W 7
`define HSC_ADR_TMR2 7'h0D
`define HSC_ADR_SD 7'h10
`define HSC_ADR_SELA 7'h14
`define HSC_ADR_SELB 7'h15
`define HSC_RST_VAL 8'h00

// writable bit masks, reserved positions are zero
`define HSC_TMR_WMASK 8'h77
`define HSC_SD_WMASK 8'h70
`define HSC_SEL_WMASK 8'h77

// field positions
`define HSC_ON_LSB 4
`define HSC_PER_LSB 0
`define HSC_SD_OV_BIT 6
`define HSC_SD_UV_BIT 5
`define HSC_SD_REC_BIT 4

// clock and microsecond tick
`define HSC_CLK_HZ 50000000
`define HSC_US_CYC (`HSC_CLK_HZ / 1000000)

// on-times in microseconds
`define HSC_TON1_US 100
`define HSC_TON2_US 300
`define HSC_TON3_US 1000
`define HSC_TON4_US 10000
`define HSC_TON5_US 20000

// periods in milliseconds
`define HSC_PER0_MS 10
`define HSC_PER1_MS 20
`define HSC_PER2_MS 50
`define HSC_PER3_MS 100
`define HSC_PER4_MS 200
`define HSC_PER5_MS 1000
`define HSC_PER6_MS 2000

// duty generator base rate and resolution
`define HSC_DUTY_HZ 200
`define HSC_DUTY_STEPS 255
`define HSC_DUTY_STEP_CYC (`HSC_CLK_HZ / (`HSC_DUTY_HZ * `HSC_DUTY_STEPS))

`endif

// [hsc_pkg.sv]
// types for the high-side switch timer control block
// no assumptions beyond the defines header
package hsc_pkg;

  // switch source selector codes
  typedef enum logic [2:0] {
    HSC_SRC_OFF = 3'b000,
    HSC_SRC_ON = 3'b001,
    HSC_SRC_T1 = 3'b010,
    HSC_SRC_T2 = 3'b011,
    HSC_SRC_D1 = 3'b100,
    HSC_SRC_D2 = 3'b101
  } hsc_src_t;

  // cyclic timer on-time codes
  typedef enum logic [2:0] {
    HSC_ON_OFF = 3'b000,
    HSC_ON_HIGH = 3'b110,
    HSC_ON_RSVD = 3'b111
  } hsc_on_t;

  // reserved period code
  localparam logic [2:0] HSC_PER_RSVD = 3'b111;

endpackage : hsc_pkg

// [hsc_cyclic_timer.sv]
// one cyclic timer: on-time and period decode, counts in microseconds
// expects a one-cycle microsecond tick and a start pulse from the register bank
`timescale 1ns/1ns
`include "hsc_defines.svh"
module hsc_cyclic_timer
  import hsc_pkg::*;
(
  input wire logic i_clk, // core clock
  input wire logic i_rst_n, // async reset, low
  input wire logic i_us_tick, // one pulse per microsecond
  input wire logic i_start, // restart the period
  input wire logic [2:0] i_on_code, // on-time code
  input wire logic [2:0] i_per_code, // period code
  output logic o_out // timer output
);

  logic [20:0] cnt_ff;
  logic [20:0] nxt_cnt;
  logic out_ff;
  logic running;
  logic [20:0] on_len;
  logic [20:0] per_len;

  // on-time lookup
  function automatic logic [20:0] on_us(input logic [2:0] code);
    case (code)
      3'h1: on_us = 21'(`HSC_TON1_US);
      3'h2: on_us = 21'(`HSC_TON2_US);
      3'h3: on_us = 21'(`HSC_TON3_US);
      3'h4: on_us = 21'(`HSC_TON4_US);
      3'h5: on_us = 21'(`HSC_TON5_US);
      default: on_us = 21'h0;
    endcase
  endfunction : on_us

  // period lookup
  function automatic logic [20:0] per_us(input logic [2:0] code);
    case (code)
      3'h0: per_us = 21'(`HSC_PER0_MS * 1000);
      3'h1: per_us = 21'(`HSC_PER1_MS * 1000);
      3'h2: per_us = 21'(`HSC_PER2_MS * 1000);
      3'h3: per_us = 21'(`HSC_PER3_MS * 1000);
      3'h4: per_us = 21'(`HSC_PER4_MS * 1000);
      3'h5: per_us = 21'(`HSC_PER5_MS * 1000);
      3'h6: per_us = 21'(`HSC_PER6_MS * 1000);
      default: per_us = 21'h1;
    endcase
  endfunction : per_us

  // running only for on codes one to five and a valid period
  assign on_len = on_us(i_on_code);
  assign per_len = per_us(i_per_code);
  assign running = (on_len != 21'h0) && (i_per_code != HSC_PER_RSVD);

  // period counter, cleared on start or when stopped
  always_comb
  begin
    if (!running || i_start)
      nxt_cnt = 21'h0;
    else if (i_us_tick)
      nxt_cnt = (cnt_ff >= per_len - 21'h1) ? 21'h0 : cnt_ff + 21'h1;
    else
      nxt_cnt = cnt_ff;
  end

  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      cnt_ff <= 21'h0;
    else
      cnt_ff <= nxt_cnt;
  end

  // high for the on-time at the start of each period
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      out_ff <= 1'b0;
    else if (i_on_code == HSC_ON_HIGH)
      out_ff <= 1'b1;
    else
      out_ff <= running && (nxt_cnt < on_len);
  end

  assign o_out = out_ff;

  AST_TMR_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_on_code == HSC_ON_OFF) |=> !o_out)
    else $error("timer output high with on-time code zero");

  AST_TMR_HIGH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_on_code == HSC_ON_HIGH) |=> (o_out && cnt_ff == 21'h0))
    else $error("timer not held high and stopped for code six");

  AST_TMR_RSVD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    (i_on_code == HSC_ON_RSVD) |=> !o_out)
    else $error("timer output high with reserved on-time code");

endmodule : hsc_cyclic_timer

// [hsc_duty_gen.sv]
// one duty-cycle generator: 255 slots per period, on while slot < duty
// expects the duty value to be steady from the register owner
`timescale 1ns/1ns
`include "hsc_defines.svh"
module hsc_duty_gen
  import hsc_pkg::*;
#(
  parameter int P_STEP_CYC = `HSC_DUTY_STEP_CYC
)
(
  input wire logic i_clk, // core clock
  input wire logic i_rst_n, // async reset, low
  input wire logic [7:0] i_duty, // duty value over 255
  output logic o_out // generator output
);

  localparam int CW = $clog2(P_STEP_CYC + 1);
  logic [CW-1:0] step_ff;
  logic [7:0] slot_ff;
  logic out_ff;
  logic step_end;

  assign step_end = (step_ff == CW'(P_STEP_CYC - 1));

  // slot prescaler
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      step_ff <= '0;
    else
      step_ff <= step_end ? '0 : step_ff + CW'(1);
  end

  // slot counter 0 to 254
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      slot_ff <= 8'h00;
    else if (step_end)
      slot_ff <= (slot_ff == 8'(`HSC_DUTY_STEPS - 1)) ? 8'h00 : slot_ff + 8'h01;
  end

  // zero is always off, all ones always on
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      out_ff <= 1'b0;
    else
      out_ff <= (i_duty == 8'hFF) || (slot_ff < i_duty);
  end

  assign o_out = out_ff;

  AST_DUTY_EDGE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    ((i_duty == 8'h00) |=> !o_out) and ((i_duty == 8'hFF) |=> o_out))
    else $error("duty output wrong for zero or full duty");

endmodule : hsc_duty_gen

// [hsc_switch_ctrl.sv]
// register bank and output logic for four high-side switches
// assumes a decoded register port, steady supply flags and fault pulses from the drivers
`timescale 1ns/1ns
`include "hsc_defines.svh"
// Operation
// - On-time code zero stops the second timer; its switches stay low.
// - On-time codes one to five give 0.1, 0.3, 1, 10, 20 ms.
// - On-time code six stops the timer and holds its switches high.
// - Period codes zero to six give 10 ms up to 2 s.
// - Writing a nonzero on-time starts the assigned timer automatically.
// - Restart clearing with cyclic sensing also clears the timer fields.
// - Reserved bits ignore writes and read as zero.
// - Overvoltage turns all switches off unless its disable bit is set.
// - Undervoltage turns all switches off unless its disable bit is set.
// - Recovery bit restores previous switch state after the supply fault.
// - First selector register holds switches one and two.
// - Second selector register holds switches three and four.
// - Selectors two and three follow the first and second timers.
// - Selectors four and five follow the duty generators.
// - Overcurrent or overtemperature clears that switch's selector.
// - Power-on or soft reset zeroes all four registers.
// - First timer uses the same encodings from its own register.
// - Duty value zero off, all ones on, else value over 255.
module hsc_switch_ctrl
  import hsc_pkg::*;
#(
  parameter int P_US_CYC = `HSC_US_CYC,
  parameter int P_DUTY_STEP_CYC = `HSC_DUTY_STEP_CYC
)
(
  input wire logic i_clk, // core clock
  input wire logic i_rst_n, // async reset, low
  input wire logic i_soft_rst, // soft reset request
  input wire logic i_wr_en, // register write strobe
  input wire logic i_rd_en, // register read strobe
  input wire logic [`HSC_ADDR_W-1:0] i_addr, // register address
  input wire logic [7:0] i_wdata, // write data
  output logic [7:0] o_rdata, // read data
  input wire logic [7:0] i_first_timer_ctrl, // first timer settings
  input wire logic [7:0] i_duty_one, // first duty value
  input wire logic [7:0] i_duty_two, // second duty value
  input wire logic i_supply_ov, // supply overvoltage
  input wire logic i_supply_uv, // supply undervoltage
  input wire logic [3:0] i_overcurrent, // per-switch overcurrent
  input wire logic [3:0] i_overtemp, // per-switch overtemperature
  input wire logic i_restart_mode, // device in restart mode
  input wire logic i_cyclic_sense, // cyclic sensing in use
  input wire logic i_restart_sw_clear, // clear switches in restart
  output logic [3:0] o_switch_on, // switch drive
  output logic o_supply_shutdown // supply shutdown active
);

  logic [7:0] tmr2_ff;
  logic [7:0] sd_ff;
  logic [7:0] sel_a_ff;
  logic [7:0] sel_b_ff;
  logic [7:0] nxt_sel_a;
  logic [7:0] nxt_sel_b;
  logic [7:0] rdata_ff;
  logic [3:0] sw_ff;
  logic shut_ff;
  logic t2_start_ff;
  logic t1_start_ff;
  logic [7:0] t1_prev_ff;
  localparam int PW = $clog2(P_US_CYC + 1);
  logic [$clog2(P_US_CYC + 1)-1:0] pre_ff;
  logic tick_ff;
  logic t1_out;
  logic t2_out;
  logic d1_out;
  logic d2_out;
  logic shut;
  logic rec;
  logic rst_clr;
  logic tmr_clr;
  logic [3:0] fault;
  logic [7:0] fmask_a;
  logic [7:0] fmask_b;
  logic [11:0] src_flat;

  // decoded strobes
  assign rst_clr = i_restart_mode && i_restart_sw_clear;
  assign tmr_clr = rst_clr && i_cyclic_sense;
  assign fault = i_overcurrent | i_overtemp;
  assign rec = sd_ff[`HSC_SD_REC_BIT];
  assign shut = (i_supply_ov && !sd_ff[`HSC_SD_OV_BIT]) || (i_supply_uv && !sd_ff[`HSC_SD_UV_BIT]);
  assign fmask_a = {1'b0, {3{fault[1]}}, 1'b0, {3{fault[0]}}};
  assign fmask_b = {1'b0, {3{fault[3]}}, 1'b0, {3{fault[2]}}};
  assign src_flat = {sel_b_ff[6:4], sel_b_ff[2:0], sel_a_ff[6:4], sel_a_ff[2:0]};

  // second timer control register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      tmr2_ff <= `HSC_RST_VAL;
    else if (i_soft_rst || tmr_clr)
      tmr2_ff <= `HSC_RST_VAL;
    else if (i_wr_en && i_addr == `HSC_ADR_TMR2)
      tmr2_ff <= i_wdata & `HSC_TMR_WMASK;
  end

  // shutdown control register
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      sd_ff <= `HSC_RST_VAL;
    else if (i_soft_rst)
      sd_ff <= `HSC_RST_VAL;
    else if (i_wr_en && i_addr == `HSC_ADR_SD)
      sd_ff <= i_wdata & `HSC_SD_WMASK;
  end

  // selector next values, hardware clears win over a write
  always_comb
  begin
    nxt_sel_a = sel_a_ff;
    nxt_sel_b = sel_b_ff;
    if (i_wr_en && i_addr == `HSC_ADR_SELA)
      nxt_sel_a = i_wdata & `HSC_SEL_WMASK;
    if (i_wr_en && i_addr == `HSC_ADR_SELB)
      nxt_sel_b = i_wdata & `HSC_SEL_WMASK;
    nxt_sel_a = nxt_sel_a & ~fmask_a;
    nxt_sel_b = nxt_sel_b & ~fmask_b;
    if (i_soft_rst || rst_clr || (shut && !rec))
    begin
      nxt_sel_a = `HSC_RST_VAL;
      nxt_sel_b = `HSC_RST_VAL;
    end
  end

  // selector registers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sel_a_ff <= `HSC_RST_VAL;
      sel_b_ff <= `HSC_RST_VAL;
    end
    else
    begin
      sel_a_ff <= nxt_sel_a;
      sel_b_ff <= nxt_sel_b;
    end
  end

  // read port, unmapped addresses read zero
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      rdata_ff <= 8'h00;
    else if (i_rd_en)
    begin
      case (i_addr)
        `HSC_ADR_TMR2: rdata_ff <= tmr2_ff;
        `HSC_ADR_SD: rdata_ff <= sd_ff;
        `HSC_ADR_SELA: rdata_ff <= sel_a_ff;
        `HSC_ADR_SELB: rdata_ff <= sel_b_ff;
        default: rdata_ff <= 8'h00;
      endcase
    end
  end

  // microsecond tick shared by both timers
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      pre_ff <= '0;
      tick_ff <= 1'b0;
    end
    else
    begin
      tick_ff <= (pre_ff == PW'(P_US_CYC - 1));
      pre_ff <= (pre_ff == PW'(P_US_CYC - 1)) ? '0 : pre_ff + PW'(1);
    end
  end

  // timer start pulses on a nonzero on-time setting
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      t2_start_ff <= 1'b0;
      t1_start_ff <= 1'b0;
      t1_prev_ff <= 8'h00;
    end
    else
    begin
      t2_start_ff <= i_wr_en && i_addr == `HSC_ADR_TMR2 && i_wdata[6:4] != 3'h0;
      t1_start_ff <= (i_first_timer_ctrl != t1_prev_ff) && i_first_timer_ctrl[6:4] != 3'h0;
      t1_prev_ff <= i_first_timer_ctrl;
    end
  end

  // first cyclic timer, same coding as the second
  hsc_cyclic_timer u_first_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_us_tick(tick_ff),
    .i_start(t1_start_ff),
    .i_on_code(i_first_timer_ctrl[6:4]),
    .i_per_code(i_first_timer_ctrl[2:0]),
    .o_out(t1_out)
  );

  // second cyclic timer
  hsc_cyclic_timer u_second_timer (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_us_tick(tick_ff),
    .i_start(t2_start_ff),
    .i_on_code(tmr2_ff[6:4]),
    .i_per_code(tmr2_ff[2:0]),
    .o_out(t2_out)
  );

  // duty generators
  hsc_duty_gen #(.P_STEP_CYC(P_DUTY_STEP_CYC)) u_first_duty (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_duty(i_duty_one),
    .o_out(d1_out)
  );

  hsc_duty_gen #(.P_STEP_CYC(P_DUTY_STEP_CYC)) u_second_duty (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_duty(i_duty_two),
    .o_out(d2_out)
  );

  // per-switch source mux and supply gating
  for (genvar k = 0; k < 4; k++)
  begin : g_sw
    logic val;
    always_comb
    begin
      case (hsc_src_t'(src_flat[3*k +: 3]))
        HSC_SRC_OFF: val = 1'b0;
        HSC_SRC_ON: val = 1'b1;
        HSC_SRC_T1: val = t1_out;
        HSC_SRC_T2: val = t2_out;
        HSC_SRC_D1: val = d1_out;
        HSC_SRC_D2: val = d2_out;
        default: val = 1'b0;
      endcase
    end
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
        sw_ff[k] <= 1'b0;
      else
        sw_ff[k] <= val && !shut;
    end
  end

  // shutdown status
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      shut_ff <= 1'b0;
    else
      shut_ff <= shut;
  end

  assign o_switch_on = sw_ff;
  assign o_supply_shutdown = shut_ff;
  assign o_rdata = rdata_ff;

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_t2_arm;
    i_wr_en && i_addr == `HSC_ADR_TMR2 && i_wdata[6:4] inside {[3'h1:3'h5]} && i_wdata[2:0] != 3'h7
      && !i_soft_rst && !tmr_clr;
  endsequence

  sequence s_fault_hold;
    shut && rec && !i_wr_en && !i_soft_rst && !rst_clr && fault == 4'h0;
  endsequence

  AST_T2_ARM: assert property (s_t2_arm |=> ##1 t2_out)
    else $error("second timer did not start after on-time write");

  AST_RSVD_READ: assert property (i_rd_en |=> (o_rdata[7] == 1'b0 && o_rdata[3] == 1'b0))
    else $error("reserved bit read as one");

  AST_OV_SHUT: assert property ((i_supply_ov && !sd_ff[`HSC_SD_OV_BIT]) |=> o_switch_on == 4'h0)
    else $error("switch on during overvoltage shutdown");

  AST_UV_SHUT: assert property ((i_supply_uv && !sd_ff[`HSC_SD_UV_BIT]) |=> o_switch_on == 4'h0)
    else $error("switch on during undervoltage shutdown");

  AST_REC_HOLD: assert property (s_fault_hold |=> $stable({sel_a_ff, sel_b_ff}))
    else $error("selectors lost during recoverable supply fault");

  AST_NOREC_CLR: assert property ((shut && !rec) |=> (sel_a_ff == 8'h00 && sel_b_ff == 8'h00))
    else $error("selectors kept without recovery");

  AST_SEL_WRITE: assert property ((i_wr_en && i_addr == `HSC_ADR_SELA && !i_soft_rst && !rst_clr
    && !shut && fault == 4'h0) |=> sel_a_ff == ($past(i_wdata) & `HSC_SEL_WMASK))
    else $error("first selector register write not stored");

  AST_FAULT_CLR: assert property ((fault != 4'h0) |=>
    ((src_flat[2:0] == 3'h0 || !$past(fault[0])) && (src_flat[11:9] == 3'h0 || !$past(fault[3]))))
    else $error("selector not cleared after switch fault");

  AST_SRC_ON: assert property ((src_flat[2:0] == HSC_SRC_ON && !shut) |=> o_switch_on[0])
    else $error("switch one off while selected on");

  AST_RESTART_CLR: assert property (tmr_clr |=> (tmr2_ff == 8'h00 && sel_a_ff == 8'h00))
    else $error("timer fields not cleared on restart clearing");

  AST_SOFT_RST: assert property (i_soft_rst |=> ({tmr2_ff, sd_ff, sel_a_ff, sel_b_ff} == 32'h0))
    else $error("registers not zero after soft reset");

endmodule : hsc_switch_ctrl

// [hsc_drv_model.sv]
// behavioural model of the switch drivers and the supply monitor
// assumes the bench commands each fault; load faults show only on a conducting switch
`timescale 1ns/1ns
module hsc_drv_model
(
  input wire logic i_clk, // core clock
  input wire logic i_rst_n, // async reset, low
  input wire logic [3:0] i_switch_on, // switch drive from the block
  input wire logic i_cmd_ov, // bench asks for overvoltage
  input wire logic i_cmd_uv, // bench asks for undervoltage
  input wire logic [3:0] i_cmd_oc, // bench asks for overcurrent
  input wire logic [3:0] i_cmd_ot, // bench asks for overtemperature
  output logic o_supply_ov, // supply overvoltage flag
  output logic o_supply_uv, // supply undervoltage flag
  output logic [3:0] o_overcurrent, // overcurrent pulse per switch
  output logic [3:0] o_overtemp // overtemperature pulse per switch
);
  // supply flags follow the command one edge later
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_supply_ov <= 1'b0;
      o_supply_uv <= 1'b0;
    end
    else
    begin
      o_supply_ov <= i_cmd_ov;
      o_supply_uv <= i_cmd_uv;
    end
  end

  // a switch that carries no current cannot report a load fault
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_overcurrent <= 4'h0;
      o_overtemp <= 4'h0;
    end
    else
    begin
      o_overcurrent <= i_cmd_oc & i_switch_on;
      o_overtemp <= i_cmd_ot & i_switch_on;
    end
  end
endmodule : hsc_drv_model

// [testbench.sv]
// self-checking bench for the switch control register bank
// assumes the driver model beside it and a 50 MHz clock
`timescale 1ns/1ns
`include "hsc_defines.svh"
module testbench
  import hsc_pkg::*;
;
  localparam int P_US = 1;
  localparam logic [6:0] ADRS [4] = '{`HSC_ADR_TMR2, `HSC_ADR_SD, `HSC_ADR_SELA, `HSC_ADR_SELB};
  localparam logic [7:0] MASKS [4] = '{8'h77, 8'h70, 8'h77, 8'h77};
  localparam logic [2:0] ONC [3] = '{3'h1, 3'h2, 3'h3};
  localparam logic [2:0] PERC [3] = '{3'h0, 3'h1, 3'h0};
  localparam int TON [3] = '{`HSC_TON1_US * P_US, `HSC_TON2_US * P_US, `HSC_TON3_US * P_US};
  localparam int TPER [3] = '{`HSC_PER0_MS * 1000 * P_US, `HSC_PER1_MS * 1000 * P_US, `HSC_PER0_MS * 1000 * P_US};
  localparam logic [7:0] SDV [5] = '{8'h40, 8'h20, 8'h10, 8'h10, 8'h00};
  localparam logic OVS [5] = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic soft_rst = 1'b0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic [6:0] addr = 7'h00;
  logic [7:0] wdata = 8'h00;
  logic [7:0] t1_ctrl = 8'h00;
  logic [7:0] duty1 = 8'h00;
  logic [7:0] duty2 = 8'h00;
  logic ov_cmd = 1'b0;
  logic uv_cmd = 1'b0;
  logic [3:0] oc_cmd = 4'h0;
  logic [3:0] ot_cmd = 4'h0;
  logic rs_mode = 1'b0;
  logic cyc_sense = 1'b0;
  logic rs_clear = 1'b0;
  logic [7:0] rdata;
  logic supply_ov;
  logic supply_uv;
  logic [3:0] overcurrent;
  logic [3:0] overtemp;
  logic [3:0] sw_on;
  logic shutdown;
  int mismatches = 0;
  int samples_checked = 0;

  // design with short microsecond and duty steps
  hsc_switch_ctrl #(.P_US_CYC(P_US), .P_DUTY_STEP_CYC(1)) u_dut (
    .i_clk(clk), .i_rst_n(rst_n), .i_soft_rst(soft_rst), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wdata(wdata), .o_rdata(rdata), .i_first_timer_ctrl(t1_ctrl),
    .i_duty_one(duty1), .i_duty_two(duty2), .i_supply_ov(supply_ov), .i_supply_uv(supply_uv),
    .i_overcurrent(overcurrent), .i_overtemp(overtemp), .i_restart_mode(rs_mode),
    .i_cyclic_sense(cyc_sense), .i_restart_sw_clear(rs_clear), .o_switch_on(sw_on),
    .o_supply_shutdown(shutdown));

  // far side: drivers and supply monitor
  hsc_drv_model u_drv (
    .i_clk(clk), .i_rst_n(rst_n), .i_switch_on(sw_on), .i_cmd_ov(ov_cmd), .i_cmd_uv(uv_cmd),
    .i_cmd_oc(oc_cmd), .i_cmd_ot(ot_cmd), .o_supply_ov(supply_ov), .o_supply_uv(supply_uv),
    .o_overcurrent(overcurrent), .o_overtemp(overtemp));

  // 50 MHz clock
  initial
  begin
    forever #10 clk = ~clk;
  end

  // every bench change lands 2 ns after a rising edge
  task automatic cyc();
    @(posedge clk);
    #2;
  endtask : cyc

  task automatic settle();
    repeat (4) cyc();
  endtask : settle

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    cyc();
    addr = a;
    wdata = d;
    wr_en = 1'b1;
    cyc();
    wr_en = 1'b0;
  endtask : wr

  task automatic note(input bit ok, input string what);
    samples_checked++;
    if (!ok)
    begin
      mismatches++;
      $display("ERROR at %0t: %s mismatch", $time, what);
    end
  endtask : note

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    note(got === exp, "register value");
  endtask : chk8

  task automatic chk4(input logic [3:0] got, input logic [3:0] exp);
    note(got === exp, "switch drive");
  endtask : chk4

  task automatic chkn(input int got, input int exp);
    note(got == exp, "cycle count");
  endtask : chkn

  // read data is registered on the taking edge
  task automatic rdchk(input logic [6:0] a, input logic [7:0] exp);
    cyc();
    addr = a;
    rd_en = 1'b1;
    cyc();
    rd_en = 1'b0;
    chk8(rdata, exp);
  endtask : rdchk

  // cycles high from a rise, then cycles from that rise to the next one
  task automatic meas(output int hi, output int per);
    int n;
    n = 0;
    hi = 0;
    per = 0;
    // skip a high phase already under way so only whole phases are counted
    while (sw_on[0] === 1'b1 && n < 300)
    begin
      cyc();
      n++;
    end
    while (sw_on[0] !== 1'b1 && n < 300)
    begin
      cyc();
      n++;
    end
    while (sw_on[0] === 1'b1 && per < 30000)
    begin
      cyc();
      hi++;
      per++;
    end
    while (sw_on[0] !== 1'b1 && per < 30000)
    begin
      cyc();
      per++;
    end
  endtask : meas

  task automatic give_verdict();
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  // watchdog: the tests need under 1 ms
  initial
  begin
    #2000000;
    mismatches++;
    $display("ERROR at %0t: watchdog expired", $time);
    give_verdict();
  end

  // test sequence
  initial
  begin
    int hi;
    int per;
    logic dis;
    repeat (5) @(posedge clk);
    #2;
    rst_n = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      rdchk(ADRS[i], `HSC_RST_VAL);
      wr(ADRS[i], 8'hFF);
      rdchk(ADRS[i], MASKS[i]);
    end
    wr(7'h11, 8'hFF);
    rdchk(7'h11, 8'h00);
    soft_rst = 1'b1;
    cyc();
    soft_rst = 1'b0;
    for (int i = 0; i < 4; i++)
      rdchk(ADRS[i], 8'h00);
    // every selector code on every switch, sources set to tell them apart
    for (int p = 0; p < 2; p++)
    begin
      t1_ctrl = p ? 8'h00 : 8'h60;
      duty1 = p ? 8'h00 : 8'hFF;
      duty2 = p ? 8'hFF : 8'h00;
      wr(`HSC_ADR_TMR2, p ? 8'h60 : 8'h00);
      for (int c = 0; c < 8; c++)
      begin
        wr(`HSC_ADR_SELA, {1'b0, c[2:0], 1'b0, c[2:0]});
        wr(`HSC_ADR_SELB, {1'b0, c[2:0], 1'b0, c[2:0]});
        settle();
        dis = (c == 1) || (c == (p ? 3 : 2)) || (c == (p ? 5 : 4));
        chk4(sw_on, {4{dis}});
        rdchk(`HSC_ADR_SELB, {1'b0, c[2:0], 1'b0, c[2:0]});
      end
    end
    // reserved timer codes leave the output low
    wr(`HSC_ADR_SELA, 8'h33);
    wr(`HSC_ADR_TMR2, 8'h70);
    settle();
    chk4(sw_on, 4'h0);
    wr(`HSC_ADR_TMR2, 8'h17);
    settle();
    chk4(sw_on, 4'h0);
    // assign first, then writing an on-time starts the timer
    wr(`HSC_ADR_SELA, 8'h03);
    for (int i = 0; i < 3; i++)
    begin
      wr(`HSC_ADR_TMR2, 8'h00);
      wr(`HSC_ADR_TMR2, {1'b0, ONC[i], 1'b0, PERC[i]});
      meas(hi, per);
      chkn(hi, TON[i]);
      chkn(per, TPER[i]);
    end
    // restart clearing, with and without cyclic sensing
    for (int s = 0; s < 2; s++)
    begin
      wr(`HSC_ADR_TMR2, 8'h10);
      wr(`HSC_ADR_SELA, 8'h03);
      cyc_sense = s[0];
      rs_mode = 1'b1;
      rs_clear = 1'b1;
      cyc();
      rs_mode = 1'b0;
      rs_clear = 1'b0;
      rdchk(`HSC_ADR_SELA, 8'h00);
      rdchk(`HSC_ADR_TMR2, s ? 8'h00 : 8'h10);
    end
    // supply faults against the disable and recovery bits
    for (int i = 0; i < 5; i++)
    begin
      wr(`HSC_ADR_SD, SDV[i]);
      wr(`HSC_ADR_SELA, 8'h11);
      ov_cmd = OVS[i];
      uv_cmd = !OVS[i];
      settle();
      dis = OVS[i] ? SDV[i][6] : SDV[i][5];
      chk4(sw_on, dis ? 4'h3 : 4'h0);
      chk4({3'b000, shutdown}, {3'b000, !dis});
      ov_cmd = 1'b0;
      uv_cmd = 1'b0;
      settle();
      chk4(sw_on, (dis || SDV[i][4]) ? 4'h3 : 4'h0);
      rdchk(`HSC_ADR_SELA, (dis || SDV[i][4]) ? 8'h11 : 8'h00);
    end
    // load faults clear only the affected selector
    wr(`HSC_ADR_SELB, 8'h11);
    // let the switches conduct first, a dark switch reports no load fault
    cyc();
    oc_cmd = 4'h4;
    cyc();
    oc_cmd = 4'h0;
    settle();
    rdchk(`HSC_ADR_SELB, 8'h10);
    chk4(sw_on, 4'h8);
    ot_cmd = 4'h8;
    cyc();
    ot_cmd = 4'h0;
    settle();
    rdchk(`HSC_ADR_SELB, 8'h00);
    // mid-range duty value is on for that many of 255 slots
    duty1 = 8'h80;
    wr(`HSC_ADR_SELA, 8'h04);
    settle();
    meas(hi, per);
    chkn(hi, 128);
    chkn(per, `HSC_DUTY_STEPS);
    give_verdict();
  end
endmodule : testbench
